// *** src/ealp_pkg.sv ***
// Overview of operation
// [RULE_01] The alert word is a 32-bit read-only value whose bit 0 shows encoder over-temperature and bit 1 encoder under-temperature.
// [RULE_02] Alert bit 2 shows encoder over-speed and bit 3 shows encoder over-acceleration.
// [RULE_03] Alert bit 4 shows a bad checksum found at storage initialisation and bit 5 shows empty storage.
// [RULE_04] Alert bit 6 shows an invalid internal parameter area, and while it is set the block drives default values.
// [RULE_05] Alert bit 7 shows an invalid decoding sequence and bit 8 an encoder flash fault.
// [RULE_06] Alert bit 9 shows unusually large shaft displacement.
// [RULE_07] Alert bit 10 is set while the battery voltage lies from 3000 to 3150 mV inclusive.
// [RULE_08] Alert bit 12 sets when the revolution counter leaves the signed 16-bit range and stays set until the command parameter is written with 2.
// [RULE_09] After leaving the signed range the revolution counter keeps counting as an unsigned 0 to 65535 value.
// [RULE_10] The speed source selector is a 16-bit read-write value, 0 by default for computed speed and 3 for encoder speed.
// [RULE_11] The gear filter depth, in 0.01 ms from 75 to 3200 with default 200, acts only when the gear filter selection is 2.
// [RULE_12] The position gain is a 16-bit value from 0 to 12000 with default 300 that a tuning load may overwrite.
// [RULE_13] The velocity feedforward is a signed value from -2000 to 2000 with default 500.
// [RULE_14] Writing 2 to the command parameter resets the encoder revolution count to zero.
// [RULE_15] A write outside a parameter's range is refused and leaves the stored value unchanged.
`default_nettype none
package ealp_pkg;

	// ==========================================================
	// parameter addresses
	localparam logic [15:0] EALP_ADDR_MT_CMD = 16'h0958;
	localparam logic [15:0] EALP_ADDR_ALERT  = 16'h0962;
	localparam logic [15:0] EALP_ADDR_SPD    = 16'h0966;
	localparam logic [15:0] EALP_ADDR_GEAR   = 16'h0968;
	localparam logic [15:0] EALP_ADDR_KPP    = 16'h096a;
	localparam logic [15:0] EALP_ADDR_PVFF   = 16'h096c;

	// ==========================================================
	// alert word bit positions
	localparam int EALP_BIT_TEMP_HI  = 0;
	localparam int EALP_BIT_TEMP_LO  = 1;
	localparam int EALP_BIT_OVSPD    = 2;
	localparam int EALP_BIT_OVACC    = 3;
	localparam int EALP_BIT_NVM_SUM  = 4;
	localparam int EALP_BIT_NVM_EMPT = 5;
	localparam int EALP_BIT_PAR_INV  = 6;
	localparam int EALP_BIT_DECODE   = 7;
	localparam int EALP_BIT_FLASH    = 8;
	localparam int EALP_BIT_SHAFT    = 9;
	localparam int EALP_BIT_BATT     = 10;
	localparam int EALP_BIT_MT_OVF   = 12;

	// ==========================================================
	// reset values and constants
	localparam logic [15:0] EALP_RST_MT_CMD  = 16'h0000;
	localparam logic [15:0] EALP_RST_SPD     = 16'h0000;
	localparam logic [31:0] EALP_RST_GEAR    = 32'h000000c8;
	localparam logic [15:0] EALP_RST_KPP     = 16'h012c;
	localparam logic [31:0] EALP_RST_PVFF    = 32'h000001f4;
	localparam logic [15:0] EALP_MT_CMD_RST  = 16'h0002;
	localparam logic [15:0] EALP_GEAR_SEL_EN = 16'h0002;
	localparam logic [15:0] EALP_BATT_LO_MV  = 16'h0bb8;
	localparam logic [15:0] EALP_BATT_HI_MV  = 16'h0c4e;
	localparam logic [15:0] EALP_KPP_MAX     = 16'h2ee0;
	localparam logic [15:0] EALP_S16_MAX     = 16'h7fff;
	localparam logic [15:0] EALP_S16_MIN     = 16'h8000;

	// ==========================================================
	// range limits, one entry per writable parameter
	localparam int EALP_NPAR    = 5;
	localparam int EALP_IX_MT   = 0;
	localparam int EALP_IX_SPD  = 1;
	localparam int EALP_IX_GEAR = 2;
	localparam int EALP_IX_KPP  = 3;
	localparam int EALP_IX_PVFF = 4;
	localparam logic signed [31:0] EALP_LIM_LO [EALP_NPAR] =
		'{32'sh00000000, 32'sh00000000, 32'sh0000004b, 32'sh00000000,
		  -32'sh000007d0};
	localparam logic signed [31:0] EALP_LIM_HI [EALP_NPAR] =
		'{32'sh00000002, 32'sh00000003, 32'sh00000c80, 32'sh00002ee0,
		  32'sh000007d0};
	// 32-bit parameters check the full word, the rest the low half
	localparam logic [EALP_NPAR-1:0] EALP_WIDE = 5'h14;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic        rd;
		logic [31:0] wdata;
	} ealp_req_t;

	typedef struct packed {
		logic [31:0] rdata;
		logic        ack;
		logic        err;
	} ealp_rsp_t;

	typedef struct packed {
		logic temp_hi;
		logic temp_lo;
		logic over_speed;
		logic over_accel;
		logic nvm_bad_sum;
		logic nvm_empty;
		logic param_invalid;
		logic bad_decode;
		logic flash_fault;
		logic big_shaft;
	} ealp_sense_t;

	typedef struct packed {
		logic [15:0] spd_src;
		logic        gear_active;
		logic [31:0] gear_depth;
		logic [15:0] position_loop_gain;
		logic [31:0] pvff;
	} ealp_param_t;

	typedef struct packed {
		ealp_sense_t sense;
		logic        batt_band;
		logic        mt_ovf;
		logic [15:0] mt_count;
		logic        mt_reset;
		logic [15:0] mt_cmd;
		logic [15:0] spd;
		logic [31:0] gear;
		logic [15:0] position_loop_gain;
		logic [31:0] pvff;
		logic [31:0] alert;
		ealp_param_t par;
		ealp_rsp_t   rsp;
	} ealp_state_t;

endpackage
`default_nettype wire

// *** src/ealp_range_chk.sv ***
`default_nettype none
module ealp_range_chk #(
	parameter logic signed [31:0] LO = 32'sh00000000,
	parameter logic signed [31:0] HI = 32'sh00000000
) (
	input  wire logic [31:0] value,
	output logic             ok
);
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// inclusive signed window
	assign ok = ($signed(value) >= LO) && ($signed(value) <= HI); // RULE_15

endmodule
`default_nettype wire

// *** src/ealp_top.sv ***
`default_nettype none
module ealp_top
	import ealp_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire ealp_req_t   req,
	input  wire ealp_sense_t sense,
	input  wire logic [15:0] battery_mv,
	input  wire logic        turn_up,
	input  wire logic        turn_down,
	input  wire logic [15:0] gear_filter_select,
	input  wire logic        tune_load,
	input  wire logic [15:0] tune_kpp,
	output ealp_rsp_t        rsp,
	output ealp_param_t      par,
	output logic [31:0]      alert_word,
	output logic [15:0]      mt_count,
	output logic             mt_reset
);
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// state
	ealp_state_t            s_q;
	ealp_state_t            s_d;
	logic [EALP_NPAR-1:0]   in_range;
	logic                   ovf_evt;
	logic                   mt_clr;
	logic                   inv;

	// ==========================================================
	// range checks on the incoming write data
	for (genvar i = 0; i < EALP_NPAR; i++) begin : g_chk
		ealp_range_chk #(
			.LO (EALP_LIM_LO[i]),
			.HI (EALP_LIM_HI[i])
		) u_chk (
			.value (EALP_WIDE[i] ? req.wdata : {16'h0000, req.wdata[15:0]}),
			.ok    (in_range[i])
		);
	end

	// ==========================================================
	// next state
	always_comb begin
		s_d = s_q;
		ovf_evt = 1'b0;
		mt_clr = 1'b0;
		s_d.rsp.ack = 1'b0;
		s_d.rsp.err = 1'b0;
		s_d.mt_reset = 1'b0;

		// live encoder conditions, one cycle of latency
		s_d.sense = sense;
		s_d.batt_band = (battery_mv >= EALP_BATT_LO_MV) &&
			(battery_mv <= EALP_BATT_HI_MV); // RULE_07

		// revolution counter; opposite steps in one cycle cancel
		if (turn_up && !turn_down) begin
			if (s_q.mt_count == EALP_S16_MAX) begin
				ovf_evt = 1'b1; // RULE_08
			end
			s_d.mt_count = s_q.mt_count + 16'h0001; // RULE_09
		end else if (turn_down && !turn_up) begin
			if (s_q.mt_count == EALP_S16_MIN) begin
				ovf_evt = 1'b1; // RULE_08
			end
			s_d.mt_count = s_q.mt_count - 16'h0001; // RULE_09
		end

		// tuning overwrite, refused when out of range
		if (tune_load && (tune_kpp <= EALP_KPP_MAX)) begin
			s_d.position_loop_gain = tune_kpp; // RULE_12
		end

		// ------------------------------------------------------
		// parameter writes; a bus write beats a tuning load
		if (req.wr) begin
			s_d.rsp.ack = 1'b1;
			case (req.addr)
				EALP_ADDR_MT_CMD: begin
					if (in_range[EALP_IX_MT]) begin
						s_d.mt_cmd = req.wdata[15:0];
						mt_clr = (req.wdata[15:0] == EALP_MT_CMD_RST);
					end else begin
						s_d.rsp.err = 1'b1; // RULE_15
					end
				end
				EALP_ADDR_SPD: begin
					if (in_range[EALP_IX_SPD]) begin
						s_d.spd = req.wdata[15:0]; // RULE_10
					end else begin
						s_d.rsp.err = 1'b1; // RULE_15
					end
				end
				EALP_ADDR_GEAR: begin
					if (in_range[EALP_IX_GEAR]) begin
						s_d.gear = req.wdata; // RULE_11
					end else begin
						s_d.rsp.err = 1'b1; // RULE_15
					end
				end
				EALP_ADDR_KPP: begin
					if (in_range[EALP_IX_KPP]) begin
						s_d.position_loop_gain = req.wdata[15:0]; // RULE_12
					end else begin
						s_d.rsp.err = 1'b1; // RULE_15
					end
				end
				EALP_ADDR_PVFF: begin
					if (in_range[EALP_IX_PVFF]) begin
						s_d.pvff = req.wdata; // RULE_13
					end else begin
						s_d.rsp.err = 1'b1; // RULE_15
					end
				end
				default: begin
					// alert word is read only, others unmapped
					s_d.rsp.err = 1'b1; // RULE_01
				end
			endcase
		end

		// command 2 zeroes the count and drops the sticky flag
		if (mt_clr) begin
			s_d.mt_count = 16'h0000; // RULE_14
			s_d.mt_ovf = 1'b0; // RULE_08
			s_d.mt_reset = 1'b1; // RULE_14
		end
		// a crossing in the clearing cycle still counts
		if (ovf_evt) begin
			s_d.mt_ovf = 1'b1; // RULE_08
		end

		// ------------------------------------------------------
		// reads return the value held before any same-cycle write
		if (req.rd) begin
			s_d.rsp.ack = 1'b1;
			case (req.addr)
				EALP_ADDR_MT_CMD: begin
					s_d.rsp.rdata = {16'h0000, s_q.mt_cmd};
				end
				EALP_ADDR_ALERT: begin
					s_d.rsp.rdata = s_q.alert; // RULE_01
				end
				EALP_ADDR_SPD: begin
					s_d.rsp.rdata = {16'h0000, s_q.spd};
				end
				EALP_ADDR_GEAR: begin
					s_d.rsp.rdata = s_q.gear;
				end
				EALP_ADDR_KPP: begin
					s_d.rsp.rdata = {16'h0000, s_q.position_loop_gain};
				end
				EALP_ADDR_PVFF: begin
					s_d.rsp.rdata = s_q.pvff;
				end
				default: begin
					s_d.rsp.rdata = 32'h00000000;
					s_d.rsp.err = 1'b1;
				end
			endcase
		end

		// ------------------------------------------------------
		// alert word, reserved bits zero
		s_d.alert = 32'h00000000;
		s_d.alert[EALP_BIT_TEMP_HI] = s_d.sense.temp_hi; // RULE_01
		s_d.alert[EALP_BIT_TEMP_LO] = s_d.sense.temp_lo; // RULE_01
		s_d.alert[EALP_BIT_OVSPD] = s_d.sense.over_speed; // RULE_02
		s_d.alert[EALP_BIT_OVACC] = s_d.sense.over_accel; // RULE_02
		s_d.alert[EALP_BIT_NVM_SUM] = s_d.sense.nvm_bad_sum; // RULE_03
		s_d.alert[EALP_BIT_NVM_EMPT] = s_d.sense.nvm_empty; // RULE_03
		s_d.alert[EALP_BIT_PAR_INV] = s_d.sense.param_invalid; // RULE_04
		s_d.alert[EALP_BIT_DECODE] = s_d.sense.bad_decode; // RULE_05
		s_d.alert[EALP_BIT_FLASH] = s_d.sense.flash_fault; // RULE_05
		s_d.alert[EALP_BIT_SHAFT] = s_d.sense.big_shaft; // RULE_06
		s_d.alert[EALP_BIT_BATT] = s_d.batt_band; // RULE_07
		s_d.alert[EALP_BIT_MT_OVF] = s_d.mt_ovf; // RULE_08

		// ------------------------------------------------------
		// effective values; stored ones survive an invalid spell
		inv = s_d.sense.param_invalid;
		s_d.par.spd_src = inv ? EALP_RST_SPD : s_d.spd; // RULE_04
		s_d.par.gear_depth = inv ? EALP_RST_GEAR : s_d.gear; // RULE_04
		s_d.par.position_loop_gain = inv ? EALP_RST_KPP : s_d.position_loop_gain; // RULE_04
		s_d.par.pvff = inv ? EALP_RST_PVFF : s_d.pvff; // RULE_04
		s_d.par.gear_active =
			(gear_filter_select == EALP_GEAR_SEL_EN); // RULE_11
	end

	// ==========================================================
	// registers
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.mt_cmd <= EALP_RST_MT_CMD;
			s_q.spd <= EALP_RST_SPD; // RULE_10
			s_q.gear <= EALP_RST_GEAR; // RULE_11
			s_q.position_loop_gain <= EALP_RST_KPP; // RULE_12
			s_q.pvff <= EALP_RST_PVFF; // RULE_13
			s_q.par.spd_src <= EALP_RST_SPD;
			s_q.par.gear_depth <= EALP_RST_GEAR;
			s_q.par.position_loop_gain <= EALP_RST_KPP;
			s_q.par.pvff <= EALP_RST_PVFF;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// outputs straight from the state register
	assign rsp = s_q.rsp;
	assign par = s_q.par;
	assign alert_word = s_q.alert;
	assign mt_count = s_q.mt_count;
	assign mt_reset = s_q.mt_reset;

endmodule
`default_nettype wire

// *** src/ealp_top_end.sv ***
`default_nettype none
`default_nettype wire

// *** test/ealp_chk.sv ***
`default_nettype none
module ealp_chk
	import ealp_pkg::*;
(
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic        ce,
	input wire ealp_req_t   req,
	input wire ealp_sense_t sense,
	input wire logic [15:0] battery_mv,
	input wire logic        turn_up,
	input wire logic        turn_down,
	input wire logic [15:0] gear_filter_select,
	input wire logic        tune_load,
	input wire logic [15:0] tune_kpp,
	input wire ealp_rsp_t   rsp,
	input wire ealp_param_t par,
	input wire logic [31:0] alert_word,
	input wire logic [15:0] mt_count,
	input wire logic        mt_reset
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// helpers
	logic [9:0] sv;
	// sense packs temp_hi first, the alert word wants it at bit 0
	assign sv = {<<{sense}};
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence s_up;
		ce && turn_up && !turn_down && !req.wr;
	endsequence
	sequence s_clr;
		ce && req.wr && req.addr == EALP_ADDR_MT_CMD && !turn_up &&
		!turn_down && req.wdata[15:0] == EALP_MT_CMD_RST;
	endsequence
	// ==========================================
	// assertions
	a_temp_bits: assert property (
		ce |=> alert_word[1:0] == $past(sv[1:0]))
		else $error("temperature bits wrong");
	a_motion_bits: assert property (
		ce |=> alert_word[3:2] == $past(sv[3:2]))
		else $error("motion bits wrong");
	a_defaults_used: assert property (
		alert_word[6] |-> par.position_loop_gain == EALP_RST_KPP &&
		par.spd_src == EALP_RST_SPD &&
		par.pvff == EALP_RST_PVFF && par.gear_depth == EALP_RST_GEAR)
		else $error("defaults not shown");
	a_fault_bits: assert property (
		ce |=> alert_word[8:7] == $past(sv[8:7]))
		else $error("fault bits wrong");
	a_batt_band: assert property (
		ce |=> alert_word[10] == ($past(battery_mv) >= EALP_BATT_LO_MV &&
		$past(battery_mv) <= EALP_BATT_HI_MV))
		else $error("battery bit wrong");
	a_ovf_set: assert property (
		s_up ##0 mt_count == EALP_S16_MAX |=>
		alert_word[12] && mt_count == EALP_S16_MIN)
		else $error("overflow not flagged");
	a_ovf_sticky: assert property (
		alert_word[12] && !(req.wr && req.addr == EALP_ADDR_MT_CMD)
		|=> alert_word[12])
		else $error("overflow flag dropped");
	a_count_step: assert property (
		s_up |=> mt_count == $past(mt_count) + 16'h0001)
		else $error("count step wrong");
	a_gear_gate: assert property (
		ce |=> par.gear_active == ($past(gear_filter_select) ==
		EALP_GEAR_SEL_EN))
		else $error("gear gate wrong");
	a_clear_cmd: assert property (
		s_clr |=> mt_count == 16'h0000 && mt_reset && !alert_word[12])
		else $error("clear command ignored");
	a_kpp_reject: assert property (
		ce && req.wr && req.addr == EALP_ADDR_KPP &&
		req.wdata[15:0] > EALP_KPP_MAX |=> rsp.err)
		else $error("bad gain accepted");
endmodule
bind ealp_top ealp_chk u_chk (.clock, .rst_b, .ce, .req, .sense,
	.battery_mv, .turn_up, .turn_down, .gear_filter_select, .tune_load,
	.tune_kpp, .rsp, .par, .alert_word, .mt_count, .mt_reset);
`default_nettype wire

// *** test/ealp_master.sv ***
`default_nettype none
module ealp_master
	import ealp_pkg::*;
(
	input  wire logic      clock,
	input  wire ealp_rsp_t rsp,
	output ealp_req_t      req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial req = '0;
	// ==========================================
	// one access, held a single cycle; answer read after the taking edge
	task automatic xfer(input logic [15:0] a, input logic w,
		input logic [31:0] d, output ealp_rsp_t o);
		@(posedge clock);
		req <= '{addr: a, wr: w, rd: !w, wdata: d};
		@(posedge clock);
		req <= '0;
		#1 o = rsp;
	endtask
endmodule
`default_nettype wire

// *** test/tb_encoder_alert_and_loop_params.sv ***
`default_nettype none
module tb_encoder_alert_and_loop_params
	import ealp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [15:0] a;
		logic [31:0] d;
		logic        e;
	} ealp_wt_t;
	localparam ealp_wt_t WT [14] = '{
		'{EALP_ADDR_SPD, 32'h3, 1'b0}, '{EALP_ADDR_SPD, 32'h4, 1'b1},
		'{EALP_ADDR_GEAR, 32'h4a, 1'b1}, '{EALP_ADDR_GEAR, 32'hc81, 1'b1},
		'{EALP_ADDR_GEAR, 32'h4b, 1'b0}, '{EALP_ADDR_GEAR, 32'hc80, 1'b0},
		'{EALP_ADDR_KPP, 32'h2ee1, 1'b1}, '{EALP_ADDR_KPP, 32'h2ee0, 1'b0},
		'{EALP_ADDR_PVFF, 32'h7d1, 1'b1}, '{EALP_ADDR_PVFF, 32'hfffff82f, 1'b1},
		'{EALP_ADDR_PVFF, 32'h7d0, 1'b0}, '{EALP_ADDR_PVFF, 32'hfffff830, 1'b0},
		'{EALP_ADDR_ALERT, 32'h0, 1'b1}, '{16'h0964, 32'h0, 1'b1}};
	logic        clock = 1'b0;
	logic        rst_b = 1'b0;
	logic        ce = 1'b1;
	logic        turn_up = 1'b0;
	logic        turn_down = 1'b0;
	logic        tune_load = 1'b0;
	logic [15:0] battery_mv = 16'h0000;
	logic [15:0] gear_filter_select = 16'h0000;
	logic [15:0] tune_kpp = 16'h0000;
	logic [15:0] bv [4] = '{16'h0bb7, 16'h0bb8, 16'h0c4e, 16'h0c4f};
	ealp_sense_t sense = '0;
	ealp_req_t   req;
	ealp_rsp_t   rsp;
	ealp_rsp_t   r;
	ealp_param_t par;
	logic [31:0] alert_word;
	logic [15:0] mt_count;
	logic        mt_reset;
	int          miscompares = 0;
	int          tests_run = 0;

	initial forever #5 clock = ~clock;
	ealp_top uut (.clock, .rst_b, .ce, .req, .sense, .battery_mv, .turn_up,
		.turn_down, .gear_filter_select, .tune_load, .tune_kpp, .rsp, .par,
		.alert_word, .mt_count, .mt_reset);
	ealp_master bus (.clock, .rsp, .req);

	// ==========================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [15:0] a);
		bus.xfer(a, 1'b0, 32'h0, r);
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================
	// scenarios
	task automatic t_limits();
		rd(EALP_ADDR_GEAR);
		chk(r.rdata, 32'hc8);
		rd(EALP_ADDR_PVFF);
		chk(r.rdata, 32'h1f4);
		foreach (WT[i]) begin
			bus.xfer(WT[i].a, 1'b1, WT[i].d, r);
			chk({r.ack, r.err}, {1'b1, WT[i].e});
		end
		rd(EALP_ADDR_SPD);
		chk(r.rdata, 32'h3);
		rd(EALP_ADDR_KPP);
		chk(r.rdata, 32'h2ee0);
		rd(EALP_ADDR_PVFF);
		chk(r.rdata, 32'hfffff830);
		$display("test limits done");
	endtask
	task automatic t_alert();
		for (int i = 0; i < 10; i++) begin
			@(posedge clock) sense <= ealp_sense_t'(10'h200 >> i);
			repeat (2) @(posedge clock);
			#1 chk(alert_word, 32'h1 << i);
			if (i == 6)
				chk(par.position_loop_gain, EALP_RST_KPP);
			if (i == 9)
				chk(alert_word[9], 1'b1);
		end
		@(posedge clock) sense <= '0;
		foreach (bv[j]) begin
			@(posedge clock) battery_mv <= bv[j];
			repeat (2) @(posedge clock);
			#1 chk(alert_word[10], j == 1 || j == 2);
		end
		$display("test alert done");
	endtask
	task automatic t_turns();
		@(posedge clock) turn_up <= 1'b1;
		repeat (32767) @(posedge clock);
		turn_up <= 1'b0;
		#1 chk({alert_word[12], mt_count}, 17'h07fff);
		@(posedge clock) turn_up <= 1'b1;
		@(posedge clock) turn_up <= 1'b0;
		#1 chk({alert_word[12], mt_count}, 17'h18000);
		bus.xfer(EALP_ADDR_MT_CMD, 1'b1, 32'h1, r);
		#20 chk(alert_word[12], 1'b1);
		bus.xfer(EALP_ADDR_MT_CMD, 1'b1, 32'h2, r);
		chk({mt_reset, alert_word[12], mt_count}, 18'h20000);
		@(posedge clock) turn_down <= 1'b1;
		@(posedge clock) turn_down <= 1'b0;
		#1 chk({alert_word[12], mt_count}, 17'h0ffff);
		$display("test turns done");
	endtask
	task automatic t_misc();
		@(posedge clock) gear_filter_select <= EALP_GEAR_SEL_EN;
		repeat (2) @(posedge clock);
		#1 chk(par.gear_active, 1'b1);
		@(posedge clock) gear_filter_select <= 16'h0001;
		tune_load <= 1'b1;
		tune_kpp <= 16'h2ee1;
		@(posedge clock) tune_kpp <= 16'h1234;
		#1 chk(par.position_loop_gain, 16'h2ee0);
		@(posedge clock) tune_load <= 1'b0;
		#1 chk({par.gear_active, par.position_loop_gain}, 17'h01234);
		chk(par.spd_src, 16'h0003);
		chk(par.pvff, 32'hfffff830);
		$display("test misc done");
	endtask
	task automatic t_hold();
		// enable low must swallow a step; then a mid-run reset
		@(posedge clock) ce <= 1'b0;
		turn_up <= 1'b1;
		@(posedge clock) ce <= 1'b1;
		turn_up <= 1'b0;
		#1 chk(mt_count, 16'hffff);
		@(posedge clock) rst_b <= 1'b0;
		@(posedge clock) rst_b <= 1'b1;
		rd(EALP_ADDR_KPP);
		chk(r.rdata, EALP_RST_KPP);
		rd(EALP_ADDR_SPD);
		chk(r.rdata, EALP_RST_SPD);
		$display("test hold done");
	endtask

	initial begin
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		t_limits();
		t_alert();
		t_turns();
		t_misc();
		t_hold();
		finish_test();
	end
	initial begin
		#500000;
		miscompares++;
		finish_test();
	end
endmodule
`default_nettype wire
